// ---- tsr_defines.vh ----
// Constants of the serial temperature sensor register block.
// Assumes inclusion by bare name from files in the same folder.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register widths and layout
`define TSR_REG_W          16
`define TSR_TEMP_W         13
`define TSR_ID_W           14
`define TSR_RX_W           8
`define TSR_CNT_W          6
`define TSR_RXN_W          4

// Power-on value of the temperature register, bits 1:0 never driven
`define TSR_POR_TEMP       16'hFF00
// Complete-conversion flag and undefined low bits
`define TSR_DONE_FLAG      1'b1
`define TSR_UNDEF_BITS     2'b00

////////////////////////////////////////////////////////////////////////////////
// Frame timing in serial clocks
`define TSR_READ_CLKS      6'h10
`define TSR_DRIVEN_CLKS    6'h0E
`define TSR_FRAME_CLKS     6'h20
`define TSR_RX_BITS        4'h8

////////////////////////////////////////////////////////////////////////////////
// Configuration codes (low byte)
`define TSR_CODE_SHDN      8'hFF
`define TSR_CODE_ONE       8'h01

////////////////////////////////////////////////////////////////////////////////
// Frame phases
`define TSR_PH_IDLE        2'h0
`define TSR_PH_READ        2'h1
`define TSR_PH_WRITE       2'h2
`define TSR_PH_HOLD        2'h3

// Synchroniser width, one bit per pin
`define TSR_SYNC_W         3

`endif

// ---- tsr_sync.v ----
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes the pins are plain levels; only the second stage is read outside.
`timescale 1ns/1ps

module tsr_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second stage
   always @(posedge clk) begin
      if (rst) begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;

endmodule

// ---- tsr_sensor.v ----
// Serial digital temperature sensor: link slave and its three registers.
// Assumes the host drives serial clock and chip select; the converter
// delivers finished samples as a one-cycle strobe on clk.
// Only a full eight-bit code, applied at deselect, changes the mode.
`timescale 1ns/1ps
`include "tsr_defines.vh"

module tsr_sensor #(
   parameter [`TSR_ID_W-1:0] ID_CODE = 14'h1A5C  // Arbitrary identity value
) (
   input  wire                   clk,
   input  wire                   rst,
   input  wire                   serial_clock_pin,
   input  wire                   cs_n_pin,
   input  wire                   sio_in,
   output wire                   sio_out,
   output wire                   sio_oe,
   input  wire                   conv_valid,
   input  wire [`TSR_TEMP_W-1:0] conv_data,
   output wire                   shutdown,
   output wire                   cfg_code_odd,
   output wire                   temp_valid
);

   ////////////////////////////////////////////////////////////////////////////
   // Frame phase codes: waiting, read clocks, write clocks, clocks past the frame
   localparam [1:0] PH_IDLE  = `TSR_PH_IDLE;
   localparam [1:0] PH_READ  = `TSR_PH_READ;
   localparam [1:0] PH_WRITE = `TSR_PH_WRITE;
   localparam [1:0] PH_HOLD  = `TSR_PH_HOLD;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   // Synchronised pin levels
   wire [`TSR_SYNC_W-1:0] pin_raw;
   wire [`TSR_SYNC_W-1:0] pin_s;
   wire                   sc_s;
   wire                   cs_n_s;
   wire                   sio_s;

   // Edge history and detected edges, all on clk
   reg                    sc_d_r;
   reg                    cs_n_d_r;
   wire                   sc_rise;
   wire                   sc_fall;
   wire                   cs_fall;
   wire                   cs_rise;

   // Phase, serial clock count, shift pending after a rise
   reg  [1:0]             phase_r;
   reg  [1:0]             phase_nxt;
   reg  [`TSR_CNT_W-1:0]  rise_cnt_r;
   reg  [`TSR_CNT_W-1:0]  rise_cnt_nxt;
   reg                    pend_r;
   reg                    pend_nxt;

   // Transmit shifter and data pin drive
   reg  [`TSR_REG_W-1:0]  tx_r;
   reg  [`TSR_REG_W-1:0]  tx_nxt;
   reg                    sio_out_r;
   reg                    sio_out_nxt;
   reg                    sio_oe_r;
   reg                    sio_oe_nxt;

   // Receive shifter and count of bits taken, saturating at eight
   reg  [`TSR_RX_W-1:0]   rx_r;
   reg  [`TSR_RX_W-1:0]   rx_nxt;
   reg  [`TSR_RXN_W-1:0]  rx_n_r;
   reg  [`TSR_RXN_W-1:0]  rx_n_nxt;

   // Mode state applied at deselect
   reg                    shutdown_r;
   reg                    shutdown_nxt;
   reg                    odd_r;
   reg                    odd_nxt;

   // Temperature register and its valid flag
   reg  [`TSR_REG_W-1:0]  temp_r;
   reg  [`TSR_REG_W-1:0]  temp_nxt;
   reg                    temp_valid_r;
   reg                    temp_valid_nxt;

   // Read word selection and code check
   wire [`TSR_REG_W-1:0]  ident_word;
   wire [`TSR_REG_W-1:0]  read_src;
   wire [`TSR_RX_W-1:0]   rx_plus_one;
   wire                   code_in_family;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // All three pins share one two-stage synchroniser and keep their relative timing
   assign pin_raw = {serial_clock_pin, cs_n_pin, sio_in};

   tsr_sync #(
      .W (`TSR_SYNC_W)
   ) u_sync (
      .clk (clk),
      .rst (rst),
      .d   (pin_raw),
      .q   (pin_s)
   );

   assign sc_s   = pin_s[2];
   assign cs_n_s = pin_s[1];
   assign sio_s  = pin_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // Edge history of the synchronised pins
   // History resets high, matching the idle select level, so reset gives no false select
   always @(posedge clk) begin
      if (rst) begin
         sc_d_r   <= 1'b1;
         cs_n_d_r <= 1'b1;
      end else begin
         sc_d_r   <= sc_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   // Serial clock edges seen only while the chip is selected
   assign sc_rise = sc_s & ~sc_d_r & ~cs_n_s;
   assign sc_fall = ~sc_s & sc_d_r & ~cs_n_s;
   assign cs_fall = ~cs_n_s & cs_n_d_r;
   assign cs_rise = cs_n_s & ~cs_n_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read source: identity in shutdown, else temperature; control word never
   // The word is snapshotted at select, so a mid-frame sample cannot tear it
   assign ident_word = {ID_CODE, `TSR_UNDEF_BITS};
   assign read_src   = shutdown_r ? ident_word : temp_r;

   // Defined codes are a run of ones from bit 0 upward
   // x & (x + 1) is zero exactly for 00, 01, 03 up to FF
   assign rx_plus_one    = rx_r + `TSR_CODE_ONE;
   assign code_in_family = ((rx_r & rx_plus_one) == {`TSR_RX_W{1'b0}});

   ////////////////////////////////////////////////////////////////////////////
   // Frame phase machine and serial engine
   always @* begin
      phase_nxt    = phase_r;
      rise_cnt_nxt = rise_cnt_r;
      pend_nxt     = pend_r;
      tx_nxt       = tx_r;
      sio_out_nxt  = sio_out_r;
      sio_oe_nxt   = sio_oe_r;
      rx_nxt       = rx_r;
      rx_n_nxt     = rx_n_r;

      case (phase_r)
         PH_IDLE: begin
            sio_oe_nxt = 1'b0;
            if (cs_fall) begin
               // Snapshot the source and put its top bit on the pin
               tx_nxt       = read_src;
               sio_out_nxt  = read_src[`TSR_REG_W-1];
               sio_oe_nxt   = 1'b1;
               // Counters restart each select; a cut frame leaves no residue
               rise_cnt_nxt = {`TSR_CNT_W{1'b0}};
               pend_nxt     = 1'b0;
               rx_n_nxt     = {`TSR_RXN_W{1'b0}};
               phase_nxt    = PH_READ;
            end
         end

         PH_READ: begin
            if (sc_rise) begin
               // Host samples here; count the clock
               rise_cnt_nxt = rise_cnt_r + 1'b1;
               pend_nxt     = 1'b1;
               if (rise_cnt_nxt == `TSR_READ_CLKS) begin
                  phase_nxt = PH_WRITE;
               end
            end else if (sc_fall && pend_r) begin
               // Next bit goes out on the falling edge; a fall with no rise
               // before it (clock idling high at select) shifts nothing
               pend_nxt    = 1'b0;
               tx_nxt      = {tx_r[`TSR_REG_W-2:0], 1'b0};
               sio_out_nxt = tx_r[`TSR_REG_W-2];
               // The last two bit times are left undriven
               sio_oe_nxt  = (rise_cnt_r < `TSR_DRIVEN_CLKS);
            end
         end

         PH_WRITE: begin
            // Host owns the pin for the whole write phase
            sio_oe_nxt = 1'b0;
            if (sc_rise) begin
               // Input sampled on the rising edge into 8-bit register
               rx_nxt       = {rx_r[`TSR_RX_W-2:0], sio_s};
               rise_cnt_nxt = rise_cnt_r + 1'b1;
               // Count saturates: a long write still keeps only eight bits
               if (rx_n_r != `TSR_RX_BITS) begin
                  rx_n_nxt = rx_n_r + 1'b1;
               end
               if (rise_cnt_nxt == `TSR_FRAME_CLKS) begin
                  phase_nxt = PH_HOLD;
               end
            end
         end

         PH_HOLD: begin
            // Clocks beyond the frame are ignored
            sio_oe_nxt = 1'b0;
         end

         default: begin
            phase_nxt  = PH_IDLE;
            sio_oe_nxt = 1'b0;
         end
      endcase

      // Deselect ends any phase and releases the pin at once
      if (cs_rise) begin
         phase_nxt  = PH_IDLE;
         sio_oe_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode state: applied only at deselect, so a read later in the same select
   // still sees the old mode; a cut write of fewer than eight bits changes nothing
   always @* begin
      shutdown_nxt = shutdown_r;
      odd_nxt      = odd_r;
      if (cs_rise && (rx_n_r == `TSR_RX_BITS)) begin
         // Last eight bits decide; all ones is shutdown, any zero wakes
         shutdown_nxt = (rx_r == `TSR_CODE_SHDN);
         // Codes outside the defined set are flagged; like any code with a zero, they still wake
         odd_nxt      = ~code_in_family;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temperature register: power-on pattern until a conversion lands
   always @* begin
      temp_nxt       = temp_r;
      temp_valid_nxt = temp_valid_r;
      // In shutdown samples are dropped; the old value stays for later reads
      if (conv_valid && !shutdown_r) begin
         // Sample in bits 15..3, done flag in bit 2
         temp_nxt       = {conv_data, `TSR_DONE_FLAG, `TSR_UNDEF_BITS};
         temp_valid_nxt = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   // Synchronous reset doubles as the power-on reset
   always @(posedge clk) begin
      if (rst) begin
         phase_r      <= PH_IDLE;
         rise_cnt_r   <= {`TSR_CNT_W{1'b0}};
         pend_r       <= 1'b0;
         tx_r         <= {`TSR_REG_W{1'b0}};
         sio_out_r    <= 1'b0;
         sio_oe_r     <= 1'b0;
         rx_r         <= {`TSR_RX_W{1'b0}};
         rx_n_r       <= {`TSR_RXN_W{1'b0}};
         shutdown_r   <= 1'b0;
         odd_r        <= 1'b0;
         temp_r       <= `TSR_POR_TEMP;
         temp_valid_r <= 1'b0;
      end else begin
         phase_r      <= phase_nxt;
         rise_cnt_r   <= rise_cnt_nxt;
         pend_r       <= pend_nxt;
         tx_r         <= tx_nxt;
         sio_out_r    <= sio_out_nxt;
         sio_oe_r     <= sio_oe_nxt;
         rx_r         <= rx_nxt;
         rx_n_r       <= rx_n_nxt;
         shutdown_r   <= shutdown_nxt;
         odd_r        <= odd_nxt;
         temp_r       <= temp_nxt;
         temp_valid_r <= temp_valid_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flip-flop
   assign sio_out      = sio_out_r;
   assign sio_oe       = sio_oe_r;
   assign shutdown     = shutdown_r;
   assign cfg_code_odd = odd_r;
   assign temp_valid   = temp_valid_r;

endmodule

// ---- tsr_sensor_chk.sv ----
// Checker: link timing and mode assertions on the sensor ports.
// Assumes the host keeps the serial clock low around select edges.
`timescale 1ns/1ps

module tsr_sensor_chk (
   input wire        clk,
   input wire        rst,
   input wire        serial_clock_pin,
   input wire        cs_n_pin,
   input wire        sio_in,
   input wire        sio_out,
   input wire        sio_oe,
   input wire        conv_valid,
   input wire [12:0] conv_data,
   input wire        shutdown,
   input wire        cfg_code_odd,
   input wire        temp_valid
);
   logic       sc_q_r;
   logic [5:0] n_rise_r;
   wire        sc_rise = serial_clock_pin & ~sc_q_r;

   // Count serial clock rises within one select
   always @(posedge clk) begin
      sc_q_r   <= serial_clock_pin;
      n_rise_r <= (rst | cs_n_pin) ? 6'h00 : n_rise_r + {5'h00, sc_rise & (n_rise_r != 6'h3F)};
   end

   ////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_sel; $fell(cs_n_pin); endsequence
   sequence s_drive; ##[1:5] sio_oe; endsequence

   property p_rst_vals; $fell(rst) |-> !shutdown && !cfg_code_odd && !temp_valid && !sio_oe; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
   property p_sel_drive; s_sel |-> s_drive; endproperty
   a_sel_drive: assert property (p_sel_drive) else $error("pin not driven after select");
   property p_idle_hiz; cs_n_pin [*5] |-> !sio_oe; endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("pin driven while deselected");
   property p_read_drive; sc_rise && !cs_n_pin && n_rise_r < 6'h0E |-> sio_oe; endproperty
   a_read_drive: assert property (p_read_drive) else $error("read bit not driven");
   property p_low_hiz; sc_rise && !cs_n_pin && n_rise_r >= 6'h0E |-> !sio_oe; endproperty
   a_low_hiz: assert property (p_low_hiz) else $error("low bits or write phase driven");
   property p_out_fall; $changed(sio_out) && $past(sio_oe) |-> !serial_clock_pin; endproperty
   a_out_fall: assert property (p_out_fall) else $error("data changed while clock high");
   property p_mode_hold; !cs_n_pin [*6] |=> $stable(shutdown) && $stable(cfg_code_odd); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed while selected");
   property p_conv; conv_valid && !shutdown |=> temp_valid; endproperty
   a_conv: assert property (p_conv) else $error("valid flag not set by sample");
endmodule

bind tsr_sensor tsr_sensor_chk tsr_sensor_chk_i (.clk(clk), .rst(rst), .serial_clock_pin(serial_clock_pin),
   .cs_n_pin(cs_n_pin), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .conv_valid(conv_valid),
   .conv_data(conv_data), .shutdown(shutdown), .cfg_code_odd(cfg_code_odd), .temp_valid(temp_valid));

// ---- tsr_host.sv ----
// Host model: serial bus master running read and write frames.
// Assumes clk is the sensor clock; serial clock low 5 clk, high 3 clk.
`timescale 1ns/1ps

module tsr_host (
   input  wire  clk,
   input  wire  dev_oe,
   input  wire  dev_out,
   output logic sclk,
   output logic cs_n,
   output wire  line
);
   logic host_oe = 1'b0;
   logic host_d = 1'b0;
   logic last_r = 1'b0;

   // Wire level; released, it shows the inverse of the last driven level
   assign line = dev_oe ? dev_out : (host_oe ? host_d : ~last_r);
   always @(posedge clk) begin
      if (dev_oe || host_oe) begin
         last_r <= line;
      end
   end
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Select, 16 read clocks, n write bits of w (MSB first), deselect
   task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rd, output logic [15:0] oe);
      cs_n <= 1'b0;
      wt(6);
      for (int i = 15; i >= 0; i--) begin
         rd[i] = line;
         oe[i] = dev_oe;
         sclk <= 1'b1;
         wt(3);
         sclk <= 1'b0;
         host_oe <= (i == 0) && (n > 0);
         host_d <= w[(n > 0) ? n - 1 : 0];
         wt(5);
      end
      for (int i = n - 1; i >= 0; i--) begin
         sclk <= 1'b1;
         wt(3);
         sclk <= 1'b0;
         host_oe <= (i > 0);
         host_d <= w[(i > 0) ? i - 1 : 0];
         wt(5);
      end
      cs_n <= 1'b1;
      wt(10);
   endtask
endmodule

// ---- tsr_sensor_tb.sv ----
// Testbench: host model runs frames; each task judges its own results.
// Assumes the host model and checker bind are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tsr_sensor_tb;
   localparam logic [13:0] ID_VAL = 14'h2C93; // Arbitrary identity value
   logic        clk;
   logic        rst = 1'b1;
   logic        conv_valid = 1'b0;
   logic [12:0] conv_data = 13'h0000;
   logic [15:0] rd;
   logic [15:0] oe;
   wire         sclk, cs_n, line, sio_out, sio_oe, shutdown, cfg_code_odd, temp_valid;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cyc = 0;

   tsr_sensor #(.ID_CODE(ID_VAL)) tsr_sensor_i (.clk(clk), .rst(rst), .serial_clock_pin(sclk), .cs_n_pin(cs_n),
      .sio_in(line), .sio_out(sio_out), .sio_oe(sio_oe), .conv_valid(conv_valid), .conv_data(conv_data),
      .shutdown(shutdown), .cfg_code_odd(cfg_code_odd), .temp_valid(temp_valid));
   tsr_host tsr_host_i (.clk(clk), .dev_oe(sio_oe), .dev_out(sio_out), .sclk(sclk), .cs_n(cs_n), .line(line));

   // Clock and cycle ceiling
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end

   task automatic results();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic conv(input logic [12:0] d);
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_data <= d;
      @(posedge clk);
      conv_valid <= 1'b0;
   endtask

   task automatic fr(input logic [15:0] w, input int n);
      tsr_host_i.frame(w, n, rd, oe);
   endtask

   ////////////////////////////////////////////////////////////
   // Power-on value and undriven low bits
   task automatic t_por();
      fr(16'h0000, 16);
      `CHK({rd[15:2], 2'b00}, 16'hFF00)
      `CHK(oe, 16'hFFFC)
      `CHK(temp_valid, 1'b0)
   endtask

   // Samples replace the power-on value, flag bit set
   task automatic t_conv();
      conv(13'h0190);
      fr(16'h0000, 16);
      `CHK({rd[15:2], 2'b00}, 16'h0C84)
      `CHK(temp_valid, 1'b1)
      conv(13'h1E70);
      fr(16'h0000, 16);
      `CHK({rd[15:2], 2'b00}, 16'hF384)
      `CHK(temp_valid, 1'b1)
   endtask

   // Shutdown gives the identity word and ignores samples
   task automatic t_shdn();
      fr(16'hA5FF, 16);
      `CHK(shutdown, 1'b1)
      conv(13'h0001);
      fr(16'h0000, 16);
      `CHK({rd[15:2], 2'b00}, {ID_VAL, 2'b00})
      `CHK(shutdown, 1'b0)
      fr(16'h0000, 16);
      `CHK({rd[15:2], 2'b00}, 16'hF384)
   endtask

   // Every defined code, last eight bits, short write refused
   task automatic t_codes();
      for (int i = 0; i < 8; i++) begin
         fr({8'h00, 8'hFF >> (8 - i)}, 8);
         `CHK({shutdown, cfg_code_odd}, 2'b00)
      end
      fr(16'h00FF, 8);
      `CHK({shutdown, cfg_code_odd}, 2'b10)
      fr(16'h0000, 4);
      `CHK(shutdown, 1'b1)
      fr(16'hFF00, 16);
      `CHK({shutdown, cfg_code_odd}, 2'b00)
   endtask

   // Reset, then the scenarios
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_por();
      t_conv();
      t_shdn();
      t_codes();
      results();
   end
endmodule
